// file: core/preset_tuning_pkg.sv
package preset_tuning_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int COUNT_W = 12;
  localparam int NUM_WORDS = 16;
  localparam int ADDR_W = 4;
  localparam int STATION_KEYS = 8;
  localparam int PIN_W = 16;

  // ----------------------------------------
  // values and cycle counts
  // ----------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_FULL = 12'hFFF;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 4'h0;
  localparam int CLEAR_CYCLES = 2;
  localparam int SETTLE_CYCLES = 4;
  localparam int TIMER_W = 4;

  // ----------------------------------------
  // positions in the synchronised pin vector
  // ----------------------------------------
  localparam int PIN_STATION = 0;
  localparam int PIN_TOGGLE = 8;
  localparam int PIN_LOW = 9;
  localparam int PIN_UP = 10;
  localparam int PIN_MANUAL = 11;
  localparam int PIN_MATCH_N = 12;
  localparam int PIN_BAND = 13;
  localparam int PIN_MODE = 14;
  localparam int PIN_STORE = 15;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    KEY_NONE,
    KEY_STATION,
    KEY_TOGGLE,
    KEY_LOW,
    KEY_UP,
    KEY_MANUAL
  } key_code_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_CHECK,
    ST_PULSE,
    ST_SETTLE,
    ST_DONE
  } seq_state_t;

endpackage

// file: core/count_if.sv
`timescale 1ns/1ns
interface count_if;
  logic clear;
  logic step;
  logic [preset_tuning_pkg::COUNT_W-1:0] count;
  logic full;

  modport ctrl (
    output clear,
    output step,
    input count,
    input full
  );

  modport cnt (
    input clear,
    input step,
    output count,
    output full
  );
endinterface

// file: core/tuning_counter.sv
`timescale 1ns/1ns
module tuning_counter (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  count_if.cnt cnt_if
);

  // ----------------------------------------
  // counter that mirrors the external one
  // ----------------------------------------
  logic [preset_tuning_pkg::COUNT_W-1:0] count;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= preset_tuning_pkg::COUNT_RESET;
    end else if (cnt_if.clear) begin
      count <= preset_tuning_pkg::COUNT_RESET;
    end else if (cnt_if.step && count != preset_tuning_pkg::COUNT_FULL) begin
      count <= count + 12'h001;
    end
  end

  assign cnt_if.count = count;
  assign cnt_if.full = (count == preset_tuning_pkg::COUNT_FULL);

endmodule

// file: core/key_priority.sv
`timescale 1ns/1ns
module key_priority (
  input wire logic [7:0] station_i,
  input wire logic bank_toggle_key_i,
  input wire logic low_key_i,
  input wire logic up_key_i,
  input wire logic manual_key_i,
  output preset_tuning_pkg::key_code_t code_o,
  output logic [2:0] index_o
);

  // ----------------------------------------
  // one key wins: D C B A H G F E, toggle, K, J, manual
  // ----------------------------------------
  always_comb begin
    code_o = preset_tuning_pkg::KEY_STATION;
    index_o = 3'h0;
    if (station_i[3]) begin
      index_o = 3'h3;
    end else if (station_i[2]) begin
      index_o = 3'h2;
    end else if (station_i[1]) begin
      index_o = 3'h1;
    end else if (station_i[0]) begin
      index_o = 3'h0;
    end else if (station_i[7]) begin
      index_o = 3'h7;
    end else if (station_i[6]) begin
      index_o = 3'h6;
    end else if (station_i[5]) begin
      index_o = 3'h5;
    end else if (station_i[4]) begin
      index_o = 3'h4;
    end else if (bank_toggle_key_i) begin
      code_o = preset_tuning_pkg::KEY_TOGGLE;
    end else if (low_key_i) begin
      code_o = preset_tuning_pkg::KEY_LOW;
    end else if (up_key_i) begin
      code_o = preset_tuning_pkg::KEY_UP;
    end else if (manual_key_i) begin
      code_o = preset_tuning_pkg::KEY_MANUAL;
    end else begin
      code_o = preset_tuning_pkg::KEY_NONE;
    end
  end

endmodule

// file: core/preset_tuning_memory_sequencer.sv
// How it works
// - manual key raises reset/manual output, holding both counters reset, manual tuning path.
// - store start drops mute and reset/manual, then clock pulses advance both counters.
// - comparator low during store stops pulses, writes counter into selected word.
// - after store, mute returns inactive and reset/manual stays low.
// - station key alone gives high reset/manual pulse and drives mute low.
// - recall pulses both counters after reset, comparing counter with addressed word.
// - counter equal to addressed word stops pulses and returns mute inactive.
// - internal and external counters get identical pulses and resets.
// - sixteen preset words, each holding one count, chosen by station key.
// - mode low gives sixteen presets, or keys choose between two banks of eight.
// - mode high gives eight presets per band, band chosen externally.
// - current address, the station number, is shown on display outputs.
// - address is four bits; the top bit also shows the band group.
// - with several keys closed only one counts, priority D C B A H G F E toggle K J manual.
`timescale 1ns/1ns
module preset_tuning_memory_sequencer #(
  parameter int CLEAR_CYCLES = preset_tuning_pkg::CLEAR_CYCLES,
  parameter int SETTLE_CYCLES = preset_tuning_pkg::SETTLE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] station_key_i,
  input wire logic store_key_i,
  input wire logic manual_key_i,
  input wire logic bank_toggle_key_i,
  input wire logic bank_low_key_i,
  input wire logic bank_up_key_i,
  input wire logic mode_i,
  input wire logic band_select_i,
  input wire logic analog_match_in_n,
  output logic reset_manual_out_o,
  output logic mute_out_n_o,
  output logic count_clk_o,
  output logic [2:0] address_low_o,
  output logic address_msb_band_out_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [preset_tuning_pkg::PIN_W-1:0] pin_raw;
  logic [preset_tuning_pkg::PIN_W-1:0] pin_meta;
  logic [preset_tuning_pkg::PIN_W-1:0] pin_sync;

  assign pin_raw = {store_key_i, mode_i, band_select_i, analog_match_in_n, manual_key_i,
                    bank_up_key_i, bank_low_key_i, bank_toggle_key_i, station_key_i};

  genvar p;
  generate
    for (p = 0; p < preset_tuning_pkg::PIN_W; p++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pin_meta[p] <= 1'b0;
          pin_sync[p] <= 1'b0;
        end else begin
          pin_meta[p] <= pin_raw[p];
          pin_sync[p] <= pin_meta[p];
        end
      end
    end
  endgenerate

  logic store_held;
  logic mode_high;
  logic band_ext;
  logic match_low;

  assign store_held = pin_sync[preset_tuning_pkg::PIN_STORE];
  assign mode_high = pin_sync[preset_tuning_pkg::PIN_MODE];
  assign band_ext = pin_sync[preset_tuning_pkg::PIN_BAND];
  assign match_low = !pin_sync[preset_tuning_pkg::PIN_MATCH_N];

  // ----------------------------------------
  // key decode and press edge
  // ----------------------------------------
  preset_tuning_pkg::key_code_t key_code;
  logic [2:0] key_index;
  logic key_seen;
  logic key_new;

  key_priority u_key_priority (
    .station_i(pin_sync[preset_tuning_pkg::PIN_STATION +: preset_tuning_pkg::STATION_KEYS]),
    .bank_toggle_key_i(pin_sync[preset_tuning_pkg::PIN_TOGGLE]),
    .low_key_i(pin_sync[preset_tuning_pkg::PIN_LOW]),
    .up_key_i(pin_sync[preset_tuning_pkg::PIN_UP]),
    .manual_key_i(pin_sync[preset_tuning_pkg::PIN_MANUAL]),
    .code_o(key_code),
    .index_o(key_index)
  );

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_seen <= 1'b0;
    end else begin
      key_seen <= (key_code != preset_tuning_pkg::KEY_NONE);
    end
  end

  assign key_new = (key_code != preset_tuning_pkg::KEY_NONE) && !key_seen;

  // ----------------------------------------
  // counter link
  // ----------------------------------------
  count_if cnt_link ();

  tuning_counter u_tuning_counter (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .cnt_if(cnt_link)
  );

  assign cnt_link.clear = reset_manual_out_o;
  assign cnt_link.step = count_clk_o;

  // ----------------------------------------
  // bank selection
  // ----------------------------------------
  preset_tuning_pkg::seq_state_t state;
  logic bank_upper;
  logic bank_now;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_upper <= 1'b0;
    end else if (key_new && !mode_high && state == preset_tuning_pkg::ST_IDLE) begin
      case (key_code)
        preset_tuning_pkg::KEY_TOGGLE: begin
          bank_upper <= !bank_upper;
        end
        preset_tuning_pkg::KEY_LOW: begin
          bank_upper <= 1'b0;
        end
        preset_tuning_pkg::KEY_UP: begin
          bank_upper <= 1'b1;
        end
        default: begin
          bank_upper <= bank_upper;
        end
      endcase
    end
  end

  assign bank_now = mode_high ? band_ext : bank_upper;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic op_store;
  logic manual_mode;
  logic [preset_tuning_pkg::TIMER_W-1:0] timer;
  logic [preset_tuning_pkg::ADDR_W-1:0] addr;
  logic [preset_tuning_pkg::COUNT_W-1:0] word_sel;
  logic finished;
  logic write_word;
  logic take_manual;
  logic take_station;
  logic start_store;
  logic check_end;

  assign finished = op_store ? match_low : (cnt_link.count == word_sel);
  assign take_manual = key_new && (key_code == preset_tuning_pkg::KEY_MANUAL)
                       && (state == preset_tuning_pkg::ST_IDLE);
  assign take_station = key_new && (key_code == preset_tuning_pkg::KEY_STATION)
                        && (state == preset_tuning_pkg::ST_IDLE);
  assign start_store = take_station && store_held && manual_mode;
  assign check_end = (state == preset_tuning_pkg::ST_CHECK) && (finished || cnt_link.full);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= preset_tuning_pkg::ST_IDLE;
    end else begin
      case (state)
        preset_tuning_pkg::ST_IDLE: begin
          if (start_store) begin
            state <= preset_tuning_pkg::ST_CHECK;
          end else if (take_station) begin
            state <= preset_tuning_pkg::ST_CLEAR;
          end
        end
        preset_tuning_pkg::ST_CLEAR: begin
          if (timer == '0) begin
            state <= preset_tuning_pkg::ST_CHECK;
          end
        end
        preset_tuning_pkg::ST_CHECK: begin
          if (check_end) begin
            state <= preset_tuning_pkg::ST_DONE;
          end else begin
            state <= preset_tuning_pkg::ST_PULSE;
          end
        end
        preset_tuning_pkg::ST_PULSE: begin
          state <= preset_tuning_pkg::ST_SETTLE;
        end
        preset_tuning_pkg::ST_SETTLE: begin
          if (timer == '0) begin
            state <= preset_tuning_pkg::ST_CHECK;
          end
        end
        preset_tuning_pkg::ST_DONE: begin
          state <= preset_tuning_pkg::ST_IDLE;
        end
        default: begin
          state <= preset_tuning_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timer <= '0;
    end else if (take_station && !start_store) begin
      timer <= preset_tuning_pkg::TIMER_W'(CLEAR_CYCLES - 1);
    end else if (state == preset_tuning_pkg::ST_PULSE) begin
      timer <= preset_tuning_pkg::TIMER_W'(SETTLE_CYCLES - 1);
    end else if ((state == preset_tuning_pkg::ST_CLEAR || state == preset_tuning_pkg::ST_SETTLE)
                 && timer != '0) begin
      timer <= timer - 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_store <= 1'b0;
    end else if (take_station) begin
      op_store <= start_store;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      manual_mode <= 1'b1;
    end else if (take_manual) begin
      manual_mode <= 1'b1;
    end else if (state == preset_tuning_pkg::ST_DONE) begin
      manual_mode <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_manual_out_o <= 1'b1;
    end else if (take_manual) begin
      reset_manual_out_o <= 1'b1;
    end else if (start_store) begin
      reset_manual_out_o <= 1'b0;
    end else if (take_station) begin
      reset_manual_out_o <= 1'b1;
    end else if (state == preset_tuning_pkg::ST_CLEAR && timer == '0) begin
      reset_manual_out_o <= 1'b0;
    end else if (state == preset_tuning_pkg::ST_DONE) begin
      reset_manual_out_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mute_out_n_o <= 1'b1;
    end else if (take_manual) begin
      mute_out_n_o <= 1'b1;
    end else if (take_station) begin
      mute_out_n_o <= 1'b0;
    end else if (state == preset_tuning_pkg::ST_DONE) begin
      mute_out_n_o <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_clk_o <= 1'b0;
      write_word <= 1'b0;
    end else begin
      count_clk_o <= (state == preset_tuning_pkg::ST_CHECK) && !check_end;
      write_word <= check_end && op_store;
    end
  end

  // ----------------------------------------
  // station address and display
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr <= preset_tuning_pkg::ADDR_RESET;
    end else if (key_new && key_code == preset_tuning_pkg::KEY_STATION
                 && state == preset_tuning_pkg::ST_IDLE) begin
      addr <= {bank_now, key_index};
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      address_low_o <= 3'h0;
      address_msb_band_out_o <= 1'b0;
    end else begin
      address_low_o <= addr[2:0];
      address_msb_band_out_o <= (state == preset_tuning_pkg::ST_IDLE) ? bank_now : addr[3];
    end
  end

  // ----------------------------------------
  // preset memory, kept through reset
  // ----------------------------------------
  logic [preset_tuning_pkg::COUNT_W-1:0] words [preset_tuning_pkg::NUM_WORDS];

  genvar w;
  generate
    for (w = 0; w < preset_tuning_pkg::NUM_WORDS; w++) begin : g_word
      always_ff @(posedge ref_clk_i) begin
        if (write_word && addr == preset_tuning_pkg::ADDR_W'(w)) begin
          words[w] <= cnt_link.count;
        end
      end
    end
  endgenerate

  assign word_sel = words[addr];

endmodule

// file: bench/preset_tuning_assertions.sv
`timescale 1ns/1ns
module preset_tuning_assertions #(
  parameter int CLEAR_CYCLES = 2,
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] station_key_i,
  input wire logic store_key_i,
  input wire logic manual_key_i,
  input wire logic bank_toggle_key_i,
  input wire logic bank_low_key_i,
  input wire logic bank_up_key_i,
  input wire logic mode_i,
  input wire logic band_select_i,
  input wire logic analog_match_in_n,
  input wire logic reset_manual_out_o,
  input wire logic mute_out_n_o,
  input wire logic count_clk_o,
  input wire logic [2:0] address_low_o,
  input wire logic address_msb_band_out_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic other_none;
  assign other_none = !manual_key_i && !bank_toggle_key_i && !bank_low_key_i && !bank_up_key_i;
  // ----------------------------------------
  // idle with every key but store released
  // ----------------------------------------
  sequence s_quiet;
    (mute_out_n_o && station_key_i == 8'h00 && other_none)[*4];
  endsequence
  property p_pulse_muted;
    count_clk_o |-> !mute_out_n_o && !reset_manual_out_o;
  endproperty
  property p_pulse_gap;
    count_clk_o |=> !count_clk_o[*5];
  endproperty
  property p_mute_hold;
    count_clk_o |=> !mute_out_n_o[*6];
  endproperty
  property p_manual;
    s_quiet ##1 (manual_key_i && station_key_i == 8'h00 && !bank_toggle_key_i && !bank_low_key_i
      && !bank_up_key_i)[*4] |=> reset_manual_out_o && mute_out_n_o;
  endproperty
  property p_recall;
    s_quiet ##1 (station_key_i != 8'h00 && !store_key_i)[*3] |=>
      (!mute_out_n_o && reset_manual_out_o)[*2] ##1 (!mute_out_n_o && !reset_manual_out_o);
  endproperty
  property p_store;
    (s_quiet ##0 (reset_manual_out_o && store_key_i)) ##1 (station_key_i != 8'h00 && store_key_i)[*4]
      |=> !mute_out_n_o && !reset_manual_out_o;
  endproperty
  property p_addr_stable;
    (!mute_out_n_o)[*3] |-> $stable(address_low_o);
  endproperty
  property p_band;
    (mute_out_n_o && mode_i && $stable(band_select_i))[*5] |-> address_msb_band_out_o == band_select_i;
  endproperty
  property p_bank_up;
    s_quiet ##1 (!mode_i && bank_up_key_i && station_key_i == 8'h00 && !bank_toggle_key_i
      && !bank_low_key_i)[*4] |=> address_msb_band_out_o;
  endproperty
  a_pulse_muted: assert property (p_pulse_muted) else $error("pulse outside muted conversion");
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulses too close");
  a_mute_hold: assert property (p_mute_hold) else $error("mute released too early");
  a_manual: assert property (p_manual) else $error("manual key not obeyed");
  a_recall: assert property (p_recall) else $error("recall start wrong");
  a_store: assert property (p_store) else $error("store start wrong");
  a_addr_stable: assert property (p_addr_stable) else $error("address moved while busy");
  a_band: assert property (p_band) else $error("band msb wrong");
  a_bank_up: assert property (p_bank_up) else $error("upper bank not selected");
  c_pulse: cover property (count_clk_o ##6 count_clk_o);
  c_done: cover property ($rose(mute_out_n_o));
  c_leave_manual: cover property ($fell(reset_manual_out_o));
endmodule

bind preset_tuning_memory_sequencer preset_tuning_assertions #(
  .CLEAR_CYCLES(CLEAR_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) preset_tuning_assertions_inst (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .station_key_i(station_key_i), .store_key_i(store_key_i),
  .manual_key_i(manual_key_i), .bank_toggle_key_i(bank_toggle_key_i), .bank_low_key_i(bank_low_key_i),
  .bank_up_key_i(bank_up_key_i), .mode_i(mode_i), .band_select_i(band_select_i),
  .analog_match_in_n(analog_match_in_n), .reset_manual_out_o(reset_manual_out_o),
  .mute_out_n_o(mute_out_n_o), .count_clk_o(count_clk_o), .address_low_o(address_low_o),
  .address_msb_band_out_o(address_msb_band_out_o)
);

// file: bench/tuning_dac_model.sv
`timescale 1ns/1ns
module tuning_dac_model (
  input wire logic ref_clk_i,
  input wire logic count_clk_i,
  input wire logic counter_reset_i,
  input wire logic slow_i,
  input wire logic [12:0] level_i,
  output logic analog_match_n_o,
  output logic [11:0] ext_count_o
);
  logic reached;
  logic reached_d;
  // ----------------------------------------
  // external counter and ladder comparator
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (counter_reset_i) begin
      ext_count_o <= 12'h000;
    end else if (count_clk_i) begin
      ext_count_o <= ext_count_o + 12'h001;
    end
  end
  assign reached = {1'b0, ext_count_o} >= level_i;
  always_ff @(posedge ref_clk_i) begin
    reached_d <= reached;
  end
  // slow mode answers one cycle late
  assign analog_match_n_o = !(slow_i ? reached_d : reached);
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] station = 8'h00;
  logic store = 1'b0, manual = 1'b0, toggle = 1'b0, low = 1'b0, up = 1'b0;
  logic mode = 1'b0, band = 1'b0, slow = 1'b0, bank = 1'b0, old = 1'b0;
  logic [12:0] level = 13'h0000;
  logic match_n, rm, mute_n, cclk, msb;
  logic [2:0] addr;
  logic [11:0] ext;
  logic [11:0] mem [16];
  logic [15:0] used = 16'h0000;
  logic [7:0] st;
  logic [3:0] slot;
  int n_errors = 0;
  int cmp_count = 0;
  integer seed = 32'h35BC595D;
  always #20 clk = ~clk;
  preset_tuning_memory_sequencer preset_tuning_memory_sequencer_inst (
    .ref_clk_i(clk), .arst_n_i(arst_n), .station_key_i(station), .store_key_i(store),
    .manual_key_i(manual), .bank_toggle_key_i(toggle), .bank_low_key_i(low), .bank_up_key_i(up),
    .mode_i(mode), .band_select_i(band), .analog_match_in_n(match_n), .reset_manual_out_o(rm),
    .mute_out_n_o(mute_n), .count_clk_o(cclk), .address_low_o(addr), .address_msb_band_out_o(msb));
  tuning_dac_model tuning_dac_model_inst (.ref_clk_i(clk), .count_clk_i(cclk), .counter_reset_i(rm),
    .slow_i(slow), .level_i(level), .analog_match_n_o(match_n), .ext_count_o(ext));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [2:0] winner(input logic [7:0] keys);
    logic [2:0] order [8] = '{3'h3, 3'h2, 3'h1, 3'h0, 3'h7, 3'h6, 3'h5, 3'h4};
    winner = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (keys[order[i]]) begin
        winner = order[i];
      end
    end
  endfunction
  // ctl is {manual, toggle, low, up}
  task automatic press(input logic [7:0] keys, input logic sto, input logic [3:0] ctl);
    int n;
    n = 0;
    @(posedge clk);
    store <= sto;
    @(posedge clk);
    station <= keys;
    {manual, toggle, low, up} <= ctl;
    repeat (6) @(negedge clk);
    while (mute_n !== 1'b1 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40000) begin
      n_errors++;
      give_verdict();
    end
    @(posedge clk);
    {station, store, manual, toggle, low, up} <= 13'h0000;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    check("reset outputs", 13'h0060, {6'h00, rm, mute_n, cclk, msb, addr});
    for (int i = 0; i < 6; i++) begin
      st = 8'($random(seed));
      if (st == 8'h00) st = 8'h09;
      bank = 1'($random(seed));
      level = (i == 0) ? 13'h0000 : 13'({$random(seed)} % 150);
      slow = 1'($random(seed));
      press(8'h00, 1'b0, bank ? 4'h1 : 4'h2);
      check("bank msb", {12'h000, bank}, {12'h000, msb});
      press(8'h00, 1'b0, 4'h8);
      check("manual hold", 13'h0001, {12'h000, rm});
      check("manual count", 13'h0000, {1'b0, ext});
      slot = {bank, winner(st)};
      press(st, 1'b1, 4'h0);
      check("store count", level, {1'b0, ext});
      check("store done", 13'h0002, {11'h000, mute_n, rm});
      check("store slot", {9'h000, slot}, {9'h000, msb, addr});
      mem[slot] = level[11:0];
      used[slot] = 1'b1;
    end
    for (int j = 0; j < 16; j++) begin
      slot = 4'(j) ^ 4'hA;
      if (used[slot]) begin
        @(posedge clk);
        mode <= j[0];
        band <= slot[3];
        press(8'h00, 1'b0, (slot[3] ^ j[0]) ? 4'h1 : 4'h2);
        check("band msb", {12'h000, slot[3]}, {12'h000, msb});
        press(8'h01 << slot[2:0], 1'b0, 4'h0);
        check("recall count", {1'b0, mem[slot]}, {1'b0, ext});
        check("recall state", 13'h0002, {11'h000, mute_n, rm});
        check("recall address", {9'h000, slot}, {9'h000, msb, addr});
      end
    end
    @(posedge clk);
    mode <= 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      old = msb;
      press(8'h00, 1'b0, 4'h4);
      check("toggle msb", {12'h000, ~old}, {12'h000, msb});
    end
    press(8'h00, 1'b0, 4'h8);
    level = 13'h1000;
    press(8'h80, 1'b1, 4'h0);
    check("full count", 13'h0FFF, {1'b0, ext});
    check("full done", 13'h0002, {11'h000, mute_n, rm});
    give_verdict();
  end
endmodule
